// >>> include/synth_tune_defs.svh
`ifndef SYNTH_TUNE_DEFS_SVH
`define SYNTH_TUNE_DEFS_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define SYNTH_HOLD_IDX 10'h05C
`define TUNE_CTRL_IDX 10'h05D
`define TUNE_STATE_IDX 10'h05E
`define CAL_RUN_IDX 10'h061
`define TRIM_IDX 10'h070
`define IRQ_STATUS_IDX 10'h071
`define IRQ_MASK_IDX 10'h072

// ****************************************
// Reset values and fields
// ****************************************
`define SYNTH_HOLD_RST 8'h00
`define TUNE_CTRL_RST 8'h40
`define CAL_RUN_RST 8'h01
`define TRIM_RST 7'h00
`define TRIM_START 7'h40
`define SETTLE_LSB 4
`define SETTLE_MSB 6
`define TRIM_MSB 6

// ****************************************
// Interrupt bits
// ****************************************
`define IRQ_TUNE_DONE 0
`define IRQ_CAL_HALT 1

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 10
`define SETTLE_UNIT_NS 160
`define SETTLE_UNIT_CYCLES ((`SETTLE_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************
// Bus responses
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> include/synth_tune_pkg.sv
package synth_tune_pkg;

  // Tuning engine states.
  typedef enum logic [1:0] {
    TUNE_IDLE = 2'b00,
    TUNE_SETTLE = 2'b01,
    TUNE_DECIDE = 2'b10
  } tune_state_e;

  typedef logic [31:0] word_t;

endpackage

// >>> design/synth_vco_tune_and_cal_run_ctrl.sv
`timescale 1ns/100ps
`include "synth_tune_defs.svh"

// Functional notes
// (RULE_01) Software sets the hold bit before programming any synthesizer setting.
// (RULE_02) Software clears the hold bit once synthesizer programming is done.
// (RULE_03) Software writes reset values into all reserved bit ranges.
// (RULE_04) Settle-select field bits 6:4, reset 4, scales wait after each trim change.
// (RULE_05) With engine enabled, tuning starts when hold is written to zero.
// (RULE_06) Engine adjusts trim code automatically until the oscillator is centred.
// (RULE_07) Software changes the tune control register only while hold is one.
// (RULE_08) Tune-complete flag in status bit 0 reads one after a finished run.
// (RULE_09) Engine disabled at hold release: tuning skipped, complete flag still one.
// (RULE_10) Software never writes the trim code during tuning.
// (RULE_11) Calibration-run bit, reset 1, runs calibration; low holds it in reset.
// (RULE_12) Clearing calibration-run also resets the digital and link clock dividers.
// (RULE_13) Software clears calibration-run before changing marked calibration registers.
// (RULE_14) Calibration-run set before link enable; link enable cleared first.
// (RULE_15) Trim code is 7-bit read/write, bits 6:0, reset 0, holds tune result.
// (RULE_16) Software neither reads nor writes trim while tuning is running.
// (RULE_17) Complete flag reads zero while hold is one or tuning runs.
module synth_vco_tune_and_cal_run_ctrl (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire synth_tune_pkg::word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output synth_tune_pkg::word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic osc_above_target,
  output logic synth_hold,
  output logic [6:0] oscillator_trim_code,
  output logic tune_active,
  output logic cal_run,
  output logic divider_reset,
  output logic irq
);
  import synth_tune_pkg::*;

  // ****************************************
  // Register bus slave
  // ****************************************
  logic aw_held, w_held, wr_lane, wr_fire, wr_hit, tune_complete, hold_prev, hold_fall;
  logic finish, complete_prev, rd_hit, hold_set;
  logic [9:0] wr_idx;
  logic [7:0] wr_byte, hold_reg, tune_ctrl, cal_reg, settle_cnt, settle_reload, rd_byte;
  logic [1:0] irq_status, irq_mask;
  tune_state_e state;
  logic [2:0] bit_idx;

  // Address and data are each held until both have arrived.
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Decodes whether a write index lands on a mapped register.
  always_comb begin
    unique case (wr_idx)
      `SYNTH_HOLD_IDX, `TUNE_CTRL_IDX, `TUNE_STATE_IDX, `CAL_RUN_IDX,
      `TRIM_IDX, `IRQ_STATUS_IDX, `IRQ_MASK_IDX: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Captures the write address.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      wr_idx <= 10'h000;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      wr_idx <= s_axi_awaddr[11:2];
    end
  end

  // Captures the write data; only the low byte lane carries register bits.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      w_held <= 1'b0;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      wr_byte <= s_axi_wdata[7:0];
      wr_lane <= s_axi_wstrb[0];
    end
  end

  // Raises the write response; unmapped addresses answer with an error.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Selects the read byte; hold, tune control and calibration run return all eight stored bits, other unused and unmapped bits read as zero.
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr[11:2])
      `SYNTH_HOLD_IDX: rd_byte = hold_reg;
      `TUNE_CTRL_IDX: rd_byte = tune_ctrl;
      `TUNE_STATE_IDX: rd_byte = {7'h00, tune_complete}; // RULE_08
      `CAL_RUN_IDX: rd_byte = cal_reg;
      `TRIM_IDX: rd_byte = {1'b0, oscillator_trim_code}; // RULE_15
      `IRQ_STATUS_IDX: rd_byte = {6'h00, irq_status};
      `IRQ_MASK_IDX: rd_byte = {6'h00, irq_mask};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Returns read data one cycle after the address is taken.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************

  // Stores hold, tune control, calibration run and mask registers.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hold_reg <= `SYNTH_HOLD_RST;
      tune_ctrl <= `TUNE_CTRL_RST;
      cal_reg <= `CAL_RUN_RST;
      irq_mask <= 2'h0;
    end else if (wr_fire && wr_lane) begin
      unique case (wr_idx)
        `SYNTH_HOLD_IDX: hold_reg <= wr_byte;
        `TUNE_CTRL_IDX: tune_ctrl <= wr_byte;
        `CAL_RUN_IDX: cal_reg <= wr_byte;
        `IRQ_MASK_IDX: irq_mask <= wr_byte[1:0];
        default: ;
      endcase
    end
  end

  // Calibration runs while the bit is high; clearing it resets the dividers.
  assign synth_hold = hold_reg[0];
  assign cal_run = cal_reg[0]; // RULE_11
  assign divider_reset = !cal_reg[0]; // RULE_12

  // ****************************************
  // Oscillator tuning engine
  // ****************************************

  // Wait per trim step grows with the settle-select field.
  assign settle_reload = 8'((32'(tune_ctrl[`SETTLE_MSB:`SETTLE_LSB]) + 32'd1)
    * `SETTLE_UNIT_CYCLES - 32'd1); // RULE_04
  assign hold_fall = hold_prev && !hold_reg[0];
  assign hold_set = wr_fire && wr_lane && wr_idx == `SYNTH_HOLD_IDX && wr_byte[0];
  assign finish = (state == TUNE_DECIDE) && (bit_idx == 3'd0) && !hold_reg[0];
  assign tune_active = (state != TUNE_IDLE);

  // Remembers the previous hold level to spot its release.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hold_prev <= 1'b0;
    end else begin
      hold_prev <= hold_reg[0];
    end
  end

  // Binary search of the trim code, one bit per settle period, MSB first.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= TUNE_IDLE;
      bit_idx <= 3'd0;
      settle_cnt <= 8'h00;
      oscillator_trim_code <= `TRIM_RST;
    end else begin
      unique case (state)
        TUNE_IDLE: begin
          if (hold_fall && tune_ctrl[0]) begin // RULE_05
            state <= TUNE_SETTLE;
            bit_idx <= 3'd`TRIM_MSB;
            settle_cnt <= settle_reload;
            oscillator_trim_code <= `TRIM_START;
          end else if (wr_fire && wr_lane && wr_idx == `TRIM_IDX) begin
            oscillator_trim_code <= wr_byte[6:0]; // RULE_15
          end
        end
        TUNE_SETTLE: begin
          if (hold_reg[0]) begin
            state <= TUNE_IDLE;
          end else if (settle_cnt == 8'h00) begin
            state <= TUNE_DECIDE;
          end else begin
            settle_cnt <= settle_cnt - 8'h01;
          end
        end
        TUNE_DECIDE: begin
          if (hold_reg[0] || bit_idx == 3'd0) begin
            state <= TUNE_IDLE;
          end else begin
            state <= TUNE_SETTLE;
            bit_idx <= bit_idx - 3'd1;
            settle_cnt <= settle_reload;
            oscillator_trim_code[bit_idx - 3'd1] <= 1'b1;
          end
          if (osc_above_target) begin
            oscillator_trim_code[bit_idx] <= 1'b0; // RULE_06
          end
        end
        default: state <= TUNE_IDLE;
      endcase
    end
  end

  // Complete flag: cleared by the hold write itself and under hold, set on finish or skip.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tune_complete <= 1'b0;
    end else if (hold_reg[0] || hold_set) begin
      tune_complete <= 1'b0; // RULE_17
    end else if (hold_fall && !tune_ctrl[0]) begin
      tune_complete <= 1'b1; // RULE_09
    end else if (finish) begin
      tune_complete <= 1'b1; // RULE_08
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************

  // Sticky events, write one to clear; a new event wins over the clear.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      complete_prev <= 1'b0;
      irq_status <= 2'h0;
    end else begin
      complete_prev <= tune_complete;
      irq_status <= (irq_status & ~((wr_fire && wr_lane && wr_idx == `IRQ_STATUS_IDX)
        ? wr_byte[1:0] : 2'h0))
        | {cal_reg[0] && wr_fire && wr_lane && wr_idx == `CAL_RUN_IDX && !wr_byte[0],
           tune_complete && !complete_prev};
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_hold_clears_done;
    synth_hold |-> !tune_complete;
  endproperty
  a_hold_clears_done: assert property (p_hold_clears_done) // RULE_17
    else $error("Complete flag high while hold is set.");
  property p_skip_done;
    hold_fall && !tune_ctrl[0] |=> tune_complete && !tune_active;
  endproperty
  a_skip_done: assert property (p_skip_done) // RULE_09
    else $error("Skipped tuning did not report completion.");
  property p_start_run;
    hold_fall && tune_ctrl[0] |=> tune_active && !tune_complete
      && oscillator_trim_code == `TRIM_START;
  endproperty
  a_start_run: assert property (p_start_run) // RULE_05
    else $error("Tuning did not start on hold release.");
  property p_settle_len;
    $rose(state == TUNE_SETTLE) && tune_ctrl[6:4] == 3'd0 ##0 (!synth_hold)[*8]
      ##1 (!synth_hold)[*8] |=> state == TUNE_DECIDE;
  endproperty
  a_settle_len: assert property (p_settle_len) // RULE_04
    else $error("Settle wait length is wrong.");
  property p_trim_clear;
    state == TUNE_DECIDE && osc_above_target && !synth_hold
      |=> !oscillator_trim_code[$past(bit_idx)];
  endproperty
  a_trim_clear: assert property (p_trim_clear) // RULE_06
    else $error("Trim bit not cleared for a fast oscillator.");
  property p_finish_done;
    finish |=> tune_complete && !tune_active;
  endproperty
  a_finish_done: assert property (p_finish_done) // RULE_08
    else $error("Finished run did not set the complete flag.");
  property p_cal_clear;
    wr_fire && wr_lane && wr_idx == `CAL_RUN_IDX && !wr_byte[0]
      |=> !cal_run && divider_reset;
  endproperty
  a_cal_clear: assert property (p_cal_clear) // RULE_12
    else $error("Clearing calibration run did not reset dividers.");
  property p_trim_write;
    wr_fire && wr_lane && wr_idx == `TRIM_IDX && !tune_active && !hold_fall
      |=> oscillator_trim_code == $past(wr_byte[6:0]);
  endproperty
  a_trim_write: assert property (p_trim_write) // RULE_15
    else $error("Trim code write not stored.");
  property p_irq_done;
    $rose(tune_complete) |=> irq_status[`IRQ_TUNE_DONE];
  endproperty
  a_irq_done: assert property (p_irq_done) // RULE_08
    else $error("Tune done event not latched.");
  c_skip: cover property (hold_fall && !tune_ctrl[0]);
  c_full_run: cover property (finish);
  c_cal_halt: cover property ($fell(cal_run));
  c_irq: cover property ($rose(irq));

endmodule // synth_vco_tune_and_cal_run_ctrl

// >>> dv/synth_vco_tune_and_cal_run_ctrl_bench.sv
`timescale 1ns/100ps
`include "synth_tune_defs.svh"

// ****************************************
// Self-checking bench for the tune and calibration run controller
// ****************************************
module synth_vco_tune_and_cal_run_ctrl_bench;
  import synth_tune_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, osc_above_target = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [3:0] s_axi_wstrb = 4'hf;
  word_t s_axi_wdata = 32'h0000_0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  word_t s_axi_rdata, rd;
  logic synth_hold, tune_active, cal_run, divider_reset, irq;
  logic [6:0] oscillator_trim_code, target = 7'h00;
  int errors = 0, checks = 0, n, sel, exp_len;
  // Shadow of the hold, tune control, calibration run and mask registers, kept from the writes the bench makes.
  int shadow[int], reg_q[$];

  synth_vco_tune_and_cal_run_ctrl synth_vco_tune_and_cal_run_ctrl_inst (.core_clk(core_clk),
    .reset(reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .osc_above_target(osc_above_target), .synth_hold(synth_hold),
    .oscillator_trim_code(oscillator_trim_code), .tune_active(tune_active), .cal_run(cal_run),
    .divider_reset(divider_reset), .irq(irq));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // Oscillator model: reports above target one clock after the trim exceeds the hidden centre code.
  always @(posedge core_clk) begin
    osc_above_target <= (oscillator_trim_code > target);
  end

  // Compares one value with its expectation and counts the outcome.
  task automatic chk(input word_t seen, input word_t exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Write cycle: address and data offered together, each released once taken.
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] st);
    logic ta, tw, da, dw, tb;
    da = 1'b0;
    dw = 1'b0;
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= st;
    s_axi_bready <= 1'b1;
    do begin
      #1;
      ta = !da && s_axi_awready === 1'b1;
      tw = !dw && s_axi_wready === 1'b1;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end while (!(da && dw));
    do begin
      #1;
      tb = s_axi_bvalid === 1'b1;
      resp = s_axi_bresp;
      @(posedge core_clk);
    end while (!tb);
    s_axi_bready <= 1'b0;
    // Mapped read/write registers take the low byte when lane 0 is enabled.
    if (st[0] && shadow.exists(int'(idx))) begin
      shadow[int'(idx)] = (idx == `IRQ_MASK_IDX) ? int'(d & 8'h03) : int'(d);
    end
  endtask

  // Read cycle with a check of data and response.
  task automatic rchk(input logic [9:0] idx, input word_t exp, input logic [1:0] er);
    logic t;
    @(posedge core_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      #1;
      t = s_axi_arready === 1'b1;
      @(posedge core_clk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      #1;
      t = s_axi_rvalid === 1'b1;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge core_clk);
    end while (!t);
    s_axi_rready <= 1'b0;
    chk(rd, exp);
    chk(resp, er);
  endtask

  // Watchdog that cuts a hang short.
  initial begin
    #400000;
    errors++;
    wrap_up();
  end

  // Main sequence of tests.
  initial begin
    void'($urandom(32'hd295));
    shadow[`SYNTH_HOLD_IDX] = int'(`SYNTH_HOLD_RST);
    shadow[`TUNE_CTRL_IDX] = int'(`TUNE_CTRL_RST);
    shadow[`CAL_RUN_IDX] = int'(`CAL_RUN_RST);
    shadow[`IRQ_MASK_IDX] = 0;
    reg_q = '{`SYNTH_HOLD_IDX, `TUNE_CTRL_IDX, `CAL_RUN_IDX, `IRQ_MASK_IDX};
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    rchk(`SYNTH_HOLD_IDX, 32'h0000_0000, `RESP_OKAY);
    rchk(`TUNE_CTRL_IDX, 32'h0000_0040, `RESP_OKAY);
    rchk(`TUNE_STATE_IDX, 32'h0000_0000, `RESP_OKAY);
    rchk(`CAL_RUN_IDX, 32'h0000_0001, `RESP_OKAY);
    rchk(`TRIM_IDX, 32'h0000_0000, `RESP_OKAY);
    chk(divider_reset, 1'b0);
    rchk(10'h3ff, 32'h0000_0000, `RESP_SLVERR);
    wr(10'h3ff, 8'h5a, 4'hf);
    chk(resp, `RESP_SLVERR);
    $display("test reset_and_map done");
    for (int k = 0; k < 2; k++) begin
      sel = k * 7;
      target = 7'($urandom_range(0, 127));
      wr(`SYNTH_HOLD_IDX, 8'h01, 4'hf);
      chk(synth_hold, 1'b1);
      wr(`TUNE_CTRL_IDX, 8'(sel << 4) | 8'h01, 4'hf);
      rchk(`TUNE_STATE_IDX, 32'h0000_0000, `RESP_OKAY);
      wr(`SYNTH_HOLD_IDX, 8'h00, 4'hf);
      n = 0;
      while (tune_active !== 1'b1 && n < 8) begin
        @(posedge core_clk);
        #1;
        n++;
      end
      chk(tune_active, 1'b1);
      n = 0;
      while (tune_active === 1'b1 && n < 2000) begin
        @(posedge core_clk);
        #1;
        n++;
      end
      exp_len = 7 * ((sel + 1) * `SETTLE_UNIT_CYCLES + 1);
      chk(n >= exp_len - 2 && n <= exp_len + 2, 1'b1);
      chk(oscillator_trim_code, target);
      rchk(`TRIM_IDX, 32'(target), `RESP_OKAY);
      rchk(`TUNE_STATE_IDX, 32'h0000_0001, `RESP_OKAY);
      $display("test tune_run settle=%0d done", sel);
    end
    wr(`SYNTH_HOLD_IDX, 8'h01, 4'hf);
    rchk(`TUNE_STATE_IDX, 32'h0000_0000, `RESP_OKAY);
    wr(`TRIM_IDX, 8'h15, 4'hf);
    wr(`TUNE_CTRL_IDX, 8'h40, 4'hf);
    wr(`SYNTH_HOLD_IDX, 8'h00, 4'hf);
    repeat (3) @(posedge core_clk);
    rchk(`TUNE_STATE_IDX, 32'h0000_0001, `RESP_OKAY);
    rchk(`TRIM_IDX, 32'h0000_0015, `RESP_OKAY);
    wr(`TRIM_IDX, 8'h33, 4'h0);
    rchk(`TRIM_IDX, 32'h0000_0015, `RESP_OKAY);
    $display("test tune_skipped done");
    wr(`IRQ_MASK_IDX, 8'h03, 4'hf);
    #1;
    chk(irq, 1'b1);
    wr(`IRQ_STATUS_IDX, 8'h03, 4'hf);
    rchk(`IRQ_STATUS_IDX, 32'h0000_0000, `RESP_OKAY);
    chk(irq, 1'b0);
    wr(`CAL_RUN_IDX, 8'h00, 4'hf);
    #1;
    chk(cal_run, 1'b0);
    chk(divider_reset, 1'b1);
    chk(irq, 1'b1);
    rchk(`IRQ_STATUS_IDX, 32'h0000_0002, `RESP_OKAY);
    wr(`IRQ_MASK_IDX, 8'h01, 4'hf);
    #1;
    chk(irq, 1'b0);
    wr(`CAL_RUN_IDX, 8'h01, 4'hf);
    #1;
    chk(cal_run, 1'b1);
    chk(divider_reset, 1'b0);
    rchk(`CAL_RUN_IDX, 32'h0000_0001, `RESP_OKAY);
    $display("test cal_run_and_irq done");
    foreach (reg_q[i]) begin
      rchk(10'(reg_q[i]), 32'(shadow[reg_q[i]]), `RESP_OKAY);
    end
    $display("test shadow_readback done");
    wrap_up();
  end
endmodule // synth_vco_tune_and_cal_run_ctrl_bench
